// file: hdl/queue_pointer.sv
`timescale 1ns/10ps
module queue_pointer #(
	parameter int W = 13
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bounds
	input wire logic [W-1:0] first,
	input wire logic [W-1:0] last,
	// control
	input wire logic advance,
	input wire logic load,
	input wire logic [W-1:0] loadValue,
	// state
	output logic [W-1:0] ptr
);
	generate
		if (W < 2) begin : g_bad_width
			$error("queue_pointer width too small");
		end
	endgenerate

	logic [W-1:0] ptr_ff;
	logic [W-1:0] nxt_ptr;

	// load wins over advance; wrap from last back to first
	assign nxt_ptr = load ? loadValue :
		(advance ? ((ptr_ff == last) ? first : W'(ptr_ff + 1'b1)) : ptr_ff);
	assign ptr = ptr_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_ff <= '0;
		end else begin
			ptr_ff <= nxt_ptr;
		end
	end
endmodule : queue_pointer

// file: hdl/tx_queue_regs.sv
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Contract
// - queue address is base above offset shifted left by one.
// - address bit zero of every queue address is always zero.
// - device advances its pending fetch pointer while fetching requests.
// - device pointer moving during a read sets the transition flag.
// - release queue spans first to last offset, wrapping between them.
// - finished packet descriptor is written at fill pointer, then pointer advances.
// - host pointer write with top bit set increments, ignoring the value.
// - empty flag when pointers match and queue holds nothing.
// - full flag when pointers match and queue is completely occupied.
// - latest congestion and flow status change recorded with circuit reference.
// - flow status field captured only in user-network mode.
module tx_queue_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus, write side
	input wire logic [txq_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [txq_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// register bus, read side
	input wire logic [txq_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [txq_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pending queue fetch engine
	input wire logic [txq_pkg::OFF_W-1:0] pendFirst,
	input wire logic [txq_pkg::OFF_W-1:0] pendLast,
	input wire logic fetchAdvance,
	output logic [txq_pkg::QADDR_W-1:0] fetchAddr,
	// transmit completion and release queue write
	input wire logic txDoneValid,
	input wire logic [txq_pkg::REG_W-1:0] txDoneDesc,
	input wire logic txDoneIoc,
	output logic relWrEn,
	output logic [txq_pkg::QADDR_W-1:0] relWrAddr,
	output logic [txq_pkg::REG_W-1:0] relWrData,
	// receive completion
	input wire logic rxBufferDone,
	// congestion and flow status change
	input wire logic cgValid,
	input wire logic cgCe,
	input wire logic [txq_pkg::GFC_W-1:0] cgGfc,
	input wire logic [txq_pkg::CIRC_W-1:0] cgCircuit,
	input wire logic uniMode,
	// dma burst control
	input wire logic dmaCycle,
	output logic dmaRelease,
	// interrupt
	output logic irq
);
	import txq_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [BASE_W-1:0] base_ff;
	logic [OFF_W-1:0] relFirst_ff;
	logic [OFF_W-1:0] relLast_ff;
	logic [REG_W-1:0] rate_ff;
	logic [REG_W-1:0] cong_ff;
	logic [IRQ_W-1:0] istat_ff;
	logic [IRQ_W-1:0] ien_ff;
	logic lastFill_ff;
	logic [CNT_W-1:0] rxCnt_ff;
	logic [CNT_W-1:0] txCnt_ff;
	logic [BURST_W-1:0] burstCnt_ff;
	logic awHeld_ff;
	logic wHeld_ff;
	logic [ADDR_W-1:0] awAddr_ff;
	logic [DATA_W-1:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic irq_ff;
	logic [QADDR_W-1:0] fetchAddr_ff;
	logic relWrEn_ff;
	logic [QADDR_W-1:0] relWrAddr_ff;
	logic [REG_W-1:0] relWrData_ff;
	logic dmaRelease_ff;
	logic [OFF_W-1:0] fetchPtr;
	logic [OFF_W-1:0] fillPtr;
	logic [OFF_W-1:0] drainPtr;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a[ADDR_W-1:2] == off[ADDR_W-1:2];
	endfunction : isReg

	function automatic logic [QADDR_W-1:0] queueAddr(input logic [BASE_W-1:0] b,
		input logic [OFF_W-1:0] o);
		return {b, o, 1'b0};
	endfunction : queueAddr

	// a limit of zero acts as one so the interrupt never goes silent
	function automatic logic countHit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
		logic [CNT_W:0] need;
		need = (lim == '0) ? (CNT_W+1)'(1) : {1'b0, lim};
		return ({1'b0, cnt} + (CNT_W+1)'(1)) >= need;
	endfunction : countHit

	function automatic logic [REG_W-1:0] mergeWord(input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : mergeWord

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire awTake = awvalid && awready_ff;
	wire wTake = wvalid && wready_ff;
	wire wrFire = awHeld_ff && wHeld_ff && !bvalid_ff;
	wire arTake = arvalid && arready_ff;
	wire wHitBase = isReg(awAddr_ff, REG_BASE);
	wire wHitRstart = isReg(awAddr_ff, REG_RSTART);
	wire wHitRend = isReg(awAddr_ff, REG_REND);
	wire wHitDrain = isReg(awAddr_ff, REG_DRAIN);
	wire wHitRate = isReg(awAddr_ff, REG_RATE);
	wire wHitIclr = isReg(awAddr_ff, REG_ICLR);
	wire wHitIen = isReg(awAddr_ff, REG_IEN);
	wire wHitRo = isReg(awAddr_ff, REG_FETCH) || isReg(awAddr_ff, REG_FILL) ||
		isReg(awAddr_ff, REG_CONG) || isReg(awAddr_ff, REG_ISTAT);
	wire wrMapped = wHitBase || wHitRstart || wHitRend || wHitDrain || wHitRate ||
		wHitIclr || wHitIen || wHitRo;
	wire [REG_W-1:0] wrOld = ({REG_W{wHitBase}} & {{(REG_W-BASE_W){1'b0}}, base_ff}) |
		({REG_W{wHitRstart}} & {3'b000, relFirst_ff}) |
		({REG_W{wHitRend}} & {3'b000, relLast_ff}) |
		({REG_W{wHitDrain}} & {3'b000, drainPtr}) |
		({REG_W{wHitRate}} & rate_ff) |
		({REG_W{wHitIen}} & {{(REG_W-IRQ_W){1'b0}}, ien_ff});
	wire [REG_W-1:0] wrVal = mergeWord(wrOld, wData_ff, wStrb_ff);

	wire rHitBase = isReg(araddr, REG_BASE);
	wire rHitFetch = isReg(araddr, REG_FETCH);
	wire rHitRstart = isReg(araddr, REG_RSTART);
	wire rHitRend = isReg(araddr, REG_REND);
	wire rHitFill = isReg(araddr, REG_FILL);
	wire rHitDrain = isReg(araddr, REG_DRAIN);
	wire rHitCong = isReg(araddr, REG_CONG);
	wire rHitRate = isReg(araddr, REG_RATE);
	wire rHitIstat = isReg(araddr, REG_ISTAT);
	wire rHitIclr = isReg(araddr, REG_ICLR);
	wire rHitIen = isReg(araddr, REG_IEN);
	wire rdMapped = rHitBase || rHitFetch || rHitRstart || rHitRend || rHitFill ||
		rHitDrain || rHitCong || rHitRate || rHitIstat || rHitIclr || rHitIen;

	// ----------------------------------------
	// queue behaviour
	// ----------------------------------------
	wire ptrMatch = fillPtr == drainPtr;
	wire relFull = ptrMatch && lastFill_ff;
	wire relEmpty = ptrMatch && !lastFill_ff;
	// a full queue refuses the descriptor and raises the overflow event instead
	wire relFire = txDoneValid && !relFull;
	wire drainWr = wrFire && wHitDrain;
	wire drainAdv = drainWr && wrVal[BIT_AUTO];
	wire drainLoad = drainWr && !wrVal[BIT_AUTO];

	// pointer moving in the sample cycle may be torn on the host side
	wire [REG_W-1:0] rdValue = ({REG_W{rHitBase}} & {{(REG_W-BASE_W){1'b0}}, base_ff}) |
		({REG_W{rHitFetch}} & {2'b00, fetchAdvance, fetchPtr}) |
		({REG_W{rHitRstart}} & {3'b000, relFirst_ff}) |
		({REG_W{rHitRend}} & {3'b000, relLast_ff}) |
		({REG_W{rHitFill}} & {2'b00, relFire, fillPtr}) |
		({REG_W{rHitDrain}} & {1'b0, relEmpty, relFull, drainPtr}) |
		({REG_W{rHitCong}} & cong_ff) |
		({REG_W{rHitRate}} & rate_ff) |
		({REG_W{rHitIstat}} & {{(REG_W-IRQ_W){1'b0}}, istat_ff}) |
		({REG_W{rHitIen}} & {{(REG_W-IRQ_W){1'b0}}, ien_ff});

	queue_pointer #(.W(OFF_W)) u_fetch (
		.clk(clk),
		.rst(rst),
		.first(pendFirst),
		.last(pendLast),
		.advance(fetchAdvance),
		.load(1'b0),
		.loadValue(RST_OFF),
		.ptr(fetchPtr)
	);

	queue_pointer #(.W(OFF_W)) u_fill (
		.clk(clk),
		.rst(rst),
		.first(relFirst_ff),
		.last(relLast_ff),
		.advance(relFire),
		.load(1'b0),
		.loadValue(RST_OFF),
		.ptr(fillPtr)
	);

	queue_pointer #(.W(OFF_W)) u_drain (
		.clk(clk),
		.rst(rst),
		.first(relFirst_ff),
		.last(relLast_ff),
		.advance(drainAdv),
		.load(drainLoad),
		.loadValue(wrVal[OFF_W-1:0]),
		.ptr(drainPtr)
	);

	// ----------------------------------------
	// interrupt rate, burst cap and events
	// ----------------------------------------
	wire rxEvent = rxBufferDone && countHit(rxCnt_ff, rate_ff[RX_CNT_LSB +: CNT_W]);
	wire txCount = txDoneValid && txDoneIoc;
	wire txEvent = txCount && countHit(txCnt_ff, rate_ff[TX_CNT_LSB +: CNT_W]);
	wire [BURST_W-1:0] burstCap = rate_ff[BURST_W-1:0];
	wire burstHit = dmaCycle && (burstCap != '0) &&
		(BURST_W'(burstCnt_ff + 1'b1) == burstCap);
	wire [IRQ_W-1:0] events = {txDoneValid && relFull, cgValid, txEvent, rxEvent};
	wire [IRQ_W-1:0] clrBits = (wrFire && wHitIclr) ? wrVal[IRQ_W-1:0] : '0;
	// set wins over a clear in the same cycle
	wire [IRQ_W-1:0] nxt_istat = (istat_ff & ~clrBits) | events;
	wire [REG_W-1:0] nxt_cong = {1'b0, cgCe, uniMode ? cgGfc : 4'h0, cgCircuit};

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= awaddr;
				awready_ff <= 1'b0;
			end
			if (wTake) begin
				wHeld_ff <= 1'b1;
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
				wready_ff <= 1'b0;
			end
			if (wrFire) begin
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else begin
			if (arTake) begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rdata_ff <= {{(DATA_W-REG_W){1'b0}}, rdValue};
				rresp_ff <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_ff && rready) begin
				rvalid_ff <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// registers and block state
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_ff <= RST_BASE;
			relFirst_ff <= RST_OFF;
			relLast_ff <= RST_OFF;
			rate_ff <= RST_RATE;
			ien_ff <= '0;
		end else if (wrFire) begin
			if (wHitBase) base_ff <= wrVal[BASE_W-1:0];
			if (wHitRstart) relFirst_ff <= wrVal[OFF_W-1:0];
			if (wHitRend) relLast_ff <= wrVal[OFF_W-1:0];
			if (wHitRate) rate_ff <= wrVal;
			if (wHitIen) ien_ff <= wrVal[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			istat_ff <= '0;
			irq_ff <= 1'b0;
			cong_ff <= '0;
			lastFill_ff <= 1'b0;
			rxCnt_ff <= '0;
			txCnt_ff <= '0;
			burstCnt_ff <= '0;
			dmaRelease_ff <= 1'b0;
		end else begin
			istat_ff <= nxt_istat;
			irq_ff <= |(istat_ff & ien_ff);
			if (cgValid) cong_ff <= nxt_cong;
			// a fill that lands on the drain pointer means full, not empty
			if (relFire) lastFill_ff <= 1'b1;
			else if (drainWr) lastFill_ff <= 1'b0;
			if (rxBufferDone) rxCnt_ff <= rxEvent ? '0 : CNT_W'(rxCnt_ff + 1'b1);
			if (txCount) txCnt_ff <= txEvent ? '0 : CNT_W'(txCnt_ff + 1'b1);
			if (dmaCycle) burstCnt_ff <= burstHit ? '0 : BURST_W'(burstCnt_ff + 1'b1);
			dmaRelease_ff <= burstHit;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetchAddr_ff <= '0;
			relWrEn_ff <= 1'b0;
			relWrAddr_ff <= '0;
			relWrData_ff <= '0;
		end else begin
			fetchAddr_ff <= queueAddr(base_ff, fetchPtr);
			relWrEn_ff <= relFire;
			if (relFire) relWrAddr_ff <= queueAddr(base_ff, fillPtr);
			if (relFire) relWrData_ff <= txDoneDesc;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign irq = irq_ff;
	assign fetchAddr = fetchAddr_ff;
	assign relWrEn = relWrEn_ff;
	assign relWrAddr = relWrAddr_ff;
	assign relWrData = relWrData_ff;
	assign dmaRelease = dmaRelease_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_read_of(logic [ADDR_W-1:0] off);
		arvalid && arready_ff && isReg(araddr, off);
	endsequence

	sequence s_drain_step;
		drainAdv && (drainPtr != relLast_ff);
	endsequence

	a_fetch_addr_form: assert property (!$past(rst) |->
		fetchAddr_ff == {$past(base_ff), $past(fetchPtr), 1'b0})
		else $error("fetch address not formed from base and offset");
	a_release_bit_zero: assert property (relWrEn_ff |-> relWrAddr_ff[0] == 1'b0)
		else $error("release address bit zero set");
	a_fetch_advance: assert property (fetchAdvance && (fetchPtr != pendLast) |=>
		fetchPtr == OFF_W'($past(fetchPtr) + 1'b1))
		else $error("fetch pointer did not advance");
	a_fetch_flag: assert property (s_read_of(REG_FETCH) and fetchAdvance |=>
		rvalid_ff && rdata_ff[BIT_TRANS])
		else $error("transition flag missing on moving pointer");
	a_fill_wrap: assert property (relFire && (fillPtr == relLast_ff) |=>
		fillPtr == $past(relFirst_ff))
		else $error("fill pointer did not wrap to first");
	a_release_write: assert property (relFire |=> relWrEn_ff &&
		relWrData_ff == $past(txDoneDesc) ##1 !relWrEn_ff || $past(relFire))
		else $error("release write missing");
	a_auto_advance: assert property (s_drain_step |=>
		drainPtr == OFF_W'($past(drainPtr) + 1'b1))
		else $error("auto advance did not increment drain pointer");
	a_empty_flag: assert property (s_read_of(REG_DRAIN) and ptrMatch && !lastFill_ff |=>
		rdata_ff[BIT_EMPTY] && !rdata_ff[BIT_FULL])
		else $error("empty flag wrong");
	a_full_flag: assert property (s_read_of(REG_DRAIN) and ptrMatch && lastFill_ff |=>
		rdata_ff[BIT_FULL] && !rdata_ff[BIT_EMPTY])
		else $error("full flag wrong");
	a_cong_capture: assert property (cgValid |=>
		cong_ff[CIRC_W-1:0] == $past(cgCircuit) && cong_ff[BIT_CE] == $past(cgCe) &&
		istat_ff[IRQ_CONG])
		else $error("congestion change not recorded");
	a_gfc_uni_only: assert property (cgValid && !uniMode |=>
		cong_ff[GFC_LSB +: GFC_W] == 4'h0)
		else $error("flow status captured outside user-network mode");
	a_rx_irq: assert property (rxEvent |=> istat_ff[IRQ_RX] && rxCnt_ff == '0)
		else $error("receive interrupt not raised at count");
	a_tx_irq: assert property (txEvent |=> istat_ff[IRQ_TX] && txCnt_ff == '0)
		else $error("release interrupt not raised at count");
	a_burst_release: assert property (dmaRelease_ff |-> $past(dmaCycle) &&
		$past(burstCap) != 8'h00 && burstCnt_ff == '0)
		else $error("bus release without a reached cap");
endmodule : tx_queue_regs

// file: hdl/txq_pkg.sv
package txq_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int OFF_W = 13;
	localparam int BASE_W = 10;
	localparam int QADDR_W = 24;
	localparam int CIRC_W = 10;
	localparam int GFC_W = 4;
	localparam int CNT_W = 4;
	localparam int BURST_W = 8;
	localparam int IRQ_W = 4;
	localparam int CLK_HZ = 40000000;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] REG_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] REG_FETCH = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RSTART = 8'h08;
	localparam logic [ADDR_W-1:0] REG_REND = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_FILL = 8'h10;
	localparam logic [ADDR_W-1:0] REG_DRAIN = 8'h14;
	localparam logic [ADDR_W-1:0] REG_CONG = 8'h18;
	localparam logic [ADDR_W-1:0] REG_RATE = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_ISTAT = 8'h20;
	localparam logic [ADDR_W-1:0] REG_ICLR = 8'h24;
	localparam logic [ADDR_W-1:0] REG_IEN = 8'h28;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_AUTO = 15;
	localparam int BIT_EMPTY = 14;
	localparam int BIT_FULL = 13;
	localparam int BIT_TRANS = 13;
	localparam int BIT_CE = 14;
	localparam int GFC_LSB = 10;
	localparam int RX_CNT_LSB = 12;
	localparam int TX_CNT_LSB = 8;
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;
	localparam int IRQ_CONG = 2;
	localparam int IRQ_OVF = 3;
	// ----------------------------------------
	// reset values and responses
	// ----------------------------------------
	localparam logic [BASE_W-1:0] RST_BASE = 10'h000;
	localparam logic [OFF_W-1:0] RST_OFF = 13'h0000;
	localparam logic [REG_W-1:0] RST_RATE = 16'h1100;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : txq_pkg

// file: test/host_mem.sv
`timescale 1ns/10ps
module host_mem (
	// clock
	input wire logic clk,
	// release queue writes from the device
	input wire logic relWrEn,
	input wire logic [txq_pkg::QADDR_W-1:0] relWrAddr,
	input wire logic [txq_pkg::REG_W-1:0] relWrData,
	// host view of the release queue
	input wire logic [txq_pkg::QADDR_W-1:0] takeAddr,
	output logic [txq_pkg::REG_W-1:0] takeDesc,
	output int wrCount
);
	import txq_pkg::*;
	// ----------------------------------------
	// descriptor memory
	// ----------------------------------------
	// small window indexed by low offset bits; the full address is kept as a tag
	logic [REG_W-1:0] mem [0:255];
	logic [QADDR_W-1:0] tag [0:255];
	logic [255:0] held = '0;
	int n = 0;
	wire [7:0] wrIdx = relWrAddr[8:1];
	wire [7:0] takeIdx = takeAddr[8:1];
	wire takeHit = held[takeIdx] && (tag[takeIdx] == takeAddr);
	always @(posedge clk) begin
		if (relWrEn === 1'b1) begin
			mem[wrIdx] <= relWrData;
			tag[wrIdx] <= relWrAddr;
			held[wrIdx] <= 1'b1;
			n <= n + 1;
		end
	end
	assign wrCount = n;
	// unwritten words read back as a changing pattern, never a stale value
	assign takeDesc = takeHit ? mem[takeIdx] : ~takeAddr[15:0];
endmodule : host_mem

// file: test/tx_queue_regs_tb.sv
`timescale 1ns/10ps
module tx_queue_regs_tb;
	import txq_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, fetchAdvance, txDoneValid, txDoneIoc, relWrEn, rxBufferDone;
	logic cgValid, cgCe, uniMode, dmaCycle, dmaRelease, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [OFF_W-1:0] pendFirst = 13'h0000, pendLast = 13'h0001;
	logic [QADDR_W-1:0] fetchAddr, relWrAddr, takeAddr;
	logic [REG_W-1:0] txDoneDesc, relWrData, takeDesc;
	logic [GFC_W-1:0] cgGfc;
	logic [CIRC_W-1:0] cgCircuit;
	logic [1:0] r;
	logic [15:0] v;
	int fails = 0, tests_run = 0, wrCount, nRel;
	tx_queue_regs dut (.*);
	host_mem host (.clk(clk), .relWrEn(relWrEn), .relWrAddr(relWrAddr), .relWrData(relWrData),
		.takeAddr(takeAddr), .takeDesc(takeDesc), .wrCount(wrCount));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		awaddr <= a; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic mv = 1'b0);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1; fetchAdvance <= mv;
		forever begin
			@(posedge clk);
			fetchAdvance <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				r = rresp;
				v = rdata[15:0];
				chk("upper half", 32'h0, {16'h0000, rdata[31:16]});
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd
	task automatic txDone(input logic [15:0] d);
		@(posedge clk);
		txDoneValid <= 1'b1; txDoneDesc <= d; txDoneIoc <= 1'b0;
		@(posedge clk);
		txDoneValid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : txDone
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_map;
		rd(REG_RATE); chk("rate reset", 16'h1100, v);
		rd(REG_IEN); chk("enable reset", 16'h0000, v);
		rd(8'h40); chk("unmapped rresp", RESP_SLVERR, r); chk("unmapped rdata", 0, v);
		wr(8'h40, 16'hFFFF); chk("unmapped bresp", RESP_SLVERR, r);
		wr(REG_FETCH, 16'h1FFF); chk("ro bresp", RESP_OKAY, r);
		rd(REG_FETCH); chk("ro kept", 16'h0000, v);
		$display("reset and map test done");
	endtask : t_reset_map
	task automatic t_fetch;
		wr(REG_BASE, 16'h0155);
		@(posedge clk) fetchAdvance <= 1'b1;
		@(posedge clk) fetchAdvance <= 1'b0;
		repeat (3) @(posedge clk);
		chk("fetch addr", {10'h155, 13'h0001, 1'b0}, fetchAddr);
		chk("fetch bit0", 1'b0, fetchAddr[0]);
		rd(REG_FETCH); chk("fetch ptr", 16'h0001, v);
		rd(REG_FETCH, 1'b1); chk("transition", 1'b1, v[BIT_TRANS]);
		rd(REG_FETCH); chk("re-read", 16'h0000, v);
		$display("fetch pointer test done");
	endtask : t_fetch
	task automatic t_release;
		wr(REG_RSTART, 16'h0000); wr(REG_REND, 16'h0001);
		rd(REG_DRAIN); chk("empty at start", 16'h4000, v);
		txDone(16'hBEEF);
		takeAddr <= {10'h155, 13'h0000, 1'b0};
		@(posedge clk);
		chk("desc 0", 16'hBEEF, takeDesc);
		txDone(16'h1234);
		takeAddr <= {10'h155, 13'h0001, 1'b0};
		@(posedge clk);
		chk("desc 1", 16'h1234, takeDesc);
		rd(REG_FILL); chk("fill wrap", 16'h0000, v & 16'h1FFF);
		rd(REG_DRAIN); chk("full", 16'h2000, v);
		txDone(16'h5555);
		chk("no write when full", 2, wrCount);
		chk("irq masked", 1'b0, irq);
		wr(REG_DRAIN, 16'h8ABC); rd(REG_DRAIN); chk("auto advance", 16'h0001, v);
		wr(REG_DRAIN, 16'h8000); rd(REG_DRAIN); chk("advance wrap", 16'h4000, v);
		$display("release queue test done");
	endtask : t_release
	task automatic t_irq_cong;
		rd(REG_ISTAT); chk("overflow status", 16'h0008, v);
		wr(REG_IEN, 16'h000C);
		repeat (2) @(posedge clk);
		chk("irq on", 1'b1, irq);
		wr(REG_ICLR, 16'h0008);
		repeat (2) @(posedge clk);
		chk("irq off", 1'b0, irq);
		@(posedge clk);
		cgValid <= 1'b1; cgCe <= 1'b1; cgGfc <= 4'hA; cgCircuit <= 10'h2AB; uniMode <= 1'b1;
		@(posedge clk) cgValid <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq congestion", 1'b1, irq);
		rd(REG_CONG); chk("indication", 16'h6AAB, v);
		@(posedge clk);
		cgValid <= 1'b1; cgCe <= 1'b0; cgCircuit <= 10'h155; uniMode <= 1'b0;
		@(posedge clk) cgValid <= 1'b0;
		rd(REG_CONG); chk("indication outside uni", 16'h0155, v);
		wr(REG_ICLR, 16'h000F); rd(REG_ISTAT); chk("cleared", 16'h0000, v);
		$display("interrupt and congestion test done");
	endtask : t_irq_cong
	task automatic t_rate;
		wr(REG_RATE, 16'h2003);
		rd(REG_RATE); chk("rate rw", 16'h2003, v);
		for (int i = 1; i <= 2; i++) begin
			@(posedge clk) rxBufferDone <= 1'b1;
			@(posedge clk) rxBufferDone <= 1'b0;
			rd(REG_ISTAT); chk("rx count", (i == 2) ? 16'h0001 : 16'h0000, v);
		end
		@(posedge clk);
		txDoneValid <= 1'b1; txDoneDesc <= 16'h0042; txDoneIoc <= 1'b1;
		@(posedge clk) txDoneValid <= 1'b0;
		rd(REG_ISTAT); chk("tx count", 1'b1, v[IRQ_TX]);
		nRel = 0;
		@(posedge clk) dmaCycle <= 1'b1;
		repeat (3) @(posedge clk) nRel += int'(dmaRelease);
		dmaCycle <= 1'b0;
		chk("early release", 0, nRel);
		repeat (3) @(posedge clk) nRel += int'(dmaRelease);
		chk("burst release", 1, nRel);
		wr(REG_RATE, 16'h2000);
		@(posedge clk) dmaCycle <= 1'b1;
		repeat (4) @(posedge clk) nRel += int'(dmaRelease);
		dmaCycle <= 1'b0;
		repeat (2) @(posedge clk) nRel += int'(dmaRelease);
		chk("unlimited burst", 1, nRel);
		$display("rate and burst test done");
	endtask : t_rate
	// ----------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; fetchAdvance = 1'b0; txDoneValid = 1'b0;
		txDoneDesc = 16'h0000; txDoneIoc = 1'b0; rxBufferDone = 1'b0; cgValid = 1'b0;
		cgCe = 1'b0; cgGfc = 4'h0; cgCircuit = 10'h000; uniMode = 1'b0; dmaCycle = 1'b0;
		takeAddr = 24'h000000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset_map();
		t_fetch();
		t_release();
		t_irq_cong();
		t_rate();
		test_done();
	end
	initial begin
		#500000;
		fails++;
		test_done();
	end
endmodule : tx_queue_regs_tb
